// >>> design/bridge_power_mgmt_csr.sv
// Purpose: Power management control and status of a bridge over APB.
// Assumes: Zero-wait APB slave; pclk at 200 MHz.
// Notes:   Read data is captured in the setup cycle of a read.
//
// Functional notes
// (R1) Two-bit power state field, 00 is D0, 11 is D3, resets to 00.
// (R2) Writes of code 01 or 10 are discarded, state unchanged.
// (R3) Writing D0 while in D3 pulses an internal reset, no bus reset.
// (R4) Bit 3 reads one: configuration kept across D3hot to D0.
// (R5) Bit 8 sticky wake enable, bit 15 sticky write-one-clear status.
// (R6) Data select, scale and data fields read zero, writes ignored.
// (R7) Bit 22 reads zero: no B2/B3 support in D3hot.
// (R8) Bit 23 reads zero: bus power and clock control disabled.
// (R9) Wake request may assert in D0, D3hot or D3cold, no wake clock.
// (R10) Event sets status; wake pin low while status and enable set.
// (R11) Reserved bits 2, 7:4 and 21:16 read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
module bridge_power_mgmt_csr
  import pm_pkg::*;
#(
  parameter int SRST_CYCLES = SRST_CYC
)(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Wake pins
  input  wire logic              pm_event_in,
  output logic                   wake_request_out_n,
  output logic                   wake_request_oe,
  // Core side
  output logic      [1:0]        power_state_out,
  output logic                   soft_reset_out,
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {SR_IDLE, SR_HOLD} srst_state_t;

  srst_state_t      sr_state_r;
  logic [7:0]       sr_cnt_r;
  logic [1:0]       ps_r;
  logic             wen_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0]      prdata_r;
  logic [31:0]      rd_word;
  logic [31:0]      csr_word;
  logic             hit;
  logic             wr;
  logic             wr_csr;
  logic             ps_wr;
  logic [1:0]       ps_code;
  logic             ps_legal;
  logic             srst_go;
  logic             drop;

  pm_wake_if wk ();

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    unique case (paddr)
      ADDR_PWR_CSR,
      ADDR_IRQ_STAT,
      ADDR_IRQ_CLR,
      ADDR_IRQ_EN: hit = 1'b1;
      default:     hit = 1'b0;
    endcase
  end

  // Every access completes at once; unmapped ones report an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  assign wr      = psel & penable & pwrite & pready & hit;
  assign wr_csr  = wr & (paddr == ADDR_PWR_CSR);
  assign ps_wr   = wr_csr & pstrb[PS_LANE];
  assign ps_code = pwdata[PS_LSB +: 2];

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  assign ps_legal = (ps_code == PS_D0) || (ps_code == PS_D3); // R1 R2
  assign drop     = ps_wr & ~ps_legal; // R2
  assign srst_go  = ps_wr & (ps_code == PS_D0) & (ps_r == PS_D3); // R3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= PS_RST; // R1
    end else if (ps_wr && ps_legal) begin
      ps_r <= ps_code; // R1 R2
    end
  end

  assign power_state_out = ps_r;

  // ----------------------------------------------------------------
  // Internal reset sequencer
  // ----------------------------------------------------------------
  // The pulse goes to the bridge core only; the bus reset pin and
  // this register bank are untouched, so configuration survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_state_r <= SR_IDLE;
      sr_cnt_r   <= 8'h00;
    end else if (srst_go) begin
      sr_state_r <= SR_HOLD; // R3
      sr_cnt_r   <= 8'(SRST_CYCLES - 1);
    end else begin
      unique case (sr_state_r)
        SR_IDLE: sr_cnt_r <= 8'h00;
        SR_HOLD: begin
          if (sr_cnt_r == 8'h00) begin
            sr_state_r <= SR_IDLE;
          end else begin
            sr_cnt_r <= sr_cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  assign soft_reset_out = (sr_state_r == SR_HOLD); // R3

  // ----------------------------------------------------------------
  // Wake enable and status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wen_r <= WEN_RST;
    end else if (wr_csr && pstrb[WK_LANE]) begin
      wen_r <= pwdata[WEN_BIT]; // R5
    end
  end

  assign wk.wake_en = wen_r;
  assign wk.clr_st  = wr_csr & pstrb[WK_LANE] & pwdata[WST_BIT]; // R5

  pm_wake_unit pm_wake_unit_i (
    .pclk               (pclk),
    .presetn            (presetn),
    .pm_event_in        (pm_event_in),
    .wake_request_out_n (wake_request_out_n),
    .wake_request_oe    (wake_request_oe),
    .bus                (wk.unit)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_WAKE] = wk.evt;
    irq_set[IRQ_SRST] = srst_go;
    irq_set[IRQ_DROP] = drop;
    irq_clr           = '0;
    if (wr && paddr == ADDR_IRQ_CLR && pstrb[0]) begin
      irq_clr = pwdata[IRQ_W-1:0];
    end
  end

  // A set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= IRQ_RST;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= IRQ_RST;
    end else if (wr && paddr == ADDR_IRQ_EN && pstrb[0]) begin
      irq_en_r <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_st_r & irq_en_r);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unlisted bits stay at zero: data select, scale, data, B2/B3,
  // bus power control and every reserved bit.
  always_comb begin
    csr_word            = 32'h0000_0000; // R6 R7 R8 R11
    csr_word[PS_LSB +: 2] = ps_r;
    csr_word[NSR_BIT]   = NSR_VAL; // R4
    csr_word[WEN_BIT]   = wen_r;
    csr_word[WST_BIT]   = wk.st;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      ADDR_PWR_CSR:  rd_word = csr_word;
      ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_st_r;
      ADDR_IRQ_EN:   rd_word[IRQ_W-1:0] = irq_en_r;
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // Capturing in setup keeps prdata a flop output with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ps_legal;
    (ps_r == PS_D0) || (ps_r == PS_D3);
  endproperty
  a_ps_legal: assert property (p_ps_legal) // R1
    else $error("power state holds an unimplemented code");

  property p_drop;
    drop |=> $stable(ps_r);
  endproperty
  a_drop: assert property (p_drop) // R2
    else $error("unimplemented state write changed the state");

  property p_srst_len;
    srst_go |=> soft_reset_out [*4];
  endproperty
  a_srst_len: assert property (p_srst_len) // R3
    else $error("internal reset pulse too short");

  property p_srst_cause;
    $rose(soft_reset_out) |-> $past(ps_r) == PS_D3 && ps_r == PS_D0;
  endproperty
  a_srst_cause: assert property (p_srst_cause) // R3
    else $error("internal reset without a D3 to D0 change");

  property p_nsr;
    (paddr == ADDR_PWR_CSR) |-> csr_word[NSR_BIT] && rd_word[NSR_BIT];
  endproperty
  a_nsr: assert property (p_nsr) // R4
    else $error("soft reset indicator not one");

  property p_nodata;
    (csr_word[31:24] == 8'h00) && (csr_word[14:9] == 6'h00);
  endproperty
  a_nodata: assert property (p_nodata) // R6
    else $error("power data fields not zero");

  property p_bse;
    csr_word[23:22] == 2'h0;
  endproperty
  a_bse: assert property (p_bse) // R7 R8
    else $error("bus support bits not zero");

  property p_rsvd;
    !csr_word[2] && csr_word[7:4] == 4'h0 && csr_word[21:16] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) // R11
    else $error("reserved bits not zero");

  property p_wake_rd;
    wk.evt |=> (csr_word[WST_BIT] && irq_st_r[IRQ_WAKE]);
  endproperty
  a_wake_rd: assert property (p_wake_rd) // R5 R10
    else $error("wake event not visible in status");

endmodule : bridge_power_mgmt_csr
`default_nettype wire

// >>> design/pm_wake_unit.sv
// Purpose: Wake event capture, sticky status and wake pin drive.
// Assumes: pm_event_in is asynchronous to pclk.
// Notes:   Only presetn and the clr_st pulse clear the sticky status bit.
`timescale 1ns/1ps
`default_nettype none
module pm_wake_unit
  import pm_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pins
  input  wire logic pm_event_in,
  output logic      wake_request_out_n,
  output logic      wake_request_oe,
  // Register bank side
  pm_wake_if.unit   bus
);

  logic [1:0] sync_r;
  logic       evt_q_r;
  logic       st_r;
  logic       evt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r  <= 2'h0;
      evt_q_r <= 1'b0;
    end else begin
      sync_r  <= {sync_r[0], pm_event_in};
      evt_q_r <= sync_r[1];
    end
  end

  assign evt     = sync_r[1] & ~evt_q_r;
  assign bus.evt = evt;
  assign bus.st  = st_r;

  // A new event in the clearing cycle keeps the bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= WST_RST;
    end else if (evt) begin
      st_r <= 1'b1; // R10
    end else if (bus.clr_st) begin
      st_r <= 1'b0; // R5
    end
  end

  // The drive ignores the power state so waking works in D0 and D3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request_oe    <= 1'b0;
      wake_request_out_n <= 1'b1;
    end else begin
      wake_request_oe    <= st_r & bus.wake_en; // R9 R10
      wake_request_out_n <= ~(st_r & bus.wake_en); // R10
    end
  end

  property p_evt_sets;
    evt |=> st_r;
  endproperty
  a_evt_sets: assert property (p_evt_sets) // R5
    else $error("wake status not set by event");

  property p_drive;
    (st_r && bus.wake_en) |=> (wake_request_oe && !wake_request_out_n);
  endproperty
  a_drive: assert property (p_drive) // R10
    else $error("wake pin not driven low");

  property p_gate;
    !bus.wake_en |=> !wake_request_oe;
  endproperty
  a_gate: assert property (p_gate) // R5
    else $error("wake pin driven while disabled");

endmodule : pm_wake_unit
`default_nettype wire

// >>> shared/pm_pkg.sv
// Purpose: Constants of the bridge power management register block.
// Assumes: APB slave with 32-bit data and byte addresses.
// Notes:   Shared by the register bank and the wake unit.
package pm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_PWR_CSR  = 12'h094;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h100;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h104;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h108;

  // ----------------------------------------------------------------
  // Power control and status word layout
  // ----------------------------------------------------------------
  localparam int PS_LSB   = 0;
  localparam int NSR_BIT  = 3;
  localparam int WEN_BIT  = 8;
  localparam int WST_BIT  = 15;
  localparam int PS_LANE  = 0;
  localparam int WK_LANE  = 1;

  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;

  localparam logic [1:0] PS_RST  = PS_D0;
  localparam logic       NSR_VAL = 1'b1;
  localparam logic       WEN_RST = 1'b0;
  localparam logic       WST_RST = 1'b0;

  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int         IRQ_W      = 3;
  localparam int         IRQ_WAKE   = 0;
  localparam int         IRQ_SRST   = 1;
  localparam int         IRQ_DROP   = 2;
  localparam logic [2:0] IRQ_RST    = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 5;
  localparam int SRST_NS  = 20;
  localparam int SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;

endpackage : pm_pkg

// >>> shared/pm_wake_if.sv
// Purpose: Link between the register bank and the wake unit.
// Assumes: Both ends run on pclk.
// Notes:   clr_st is a one-cycle pulse, evt a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface pm_wake_if;
  logic wake_en;
  logic clr_st;
  logic st;
  logic evt;
  modport ctrl (output wake_en, output clr_st, input st, input evt);
  modport unit (input wake_en, input clr_st, output st, output evt);
endinterface : pm_wake_if
`default_nettype wire

// >>> test/bridge_power_mgmt_csr_tb.sv
// Purpose: Self-checking bench for the bridge power management registers.
// Assumes: Zero-wait APB slave; the bench drives every pin itself.
// Notes:   Soft reset length is set to four cycles and checked as such.
`timescale 1ns/1ps
`default_nettype none
module bridge_power_mgmt_csr_tb;
  import pm_pkg::*;

  localparam int SRST_T = 4;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pm_event_in;
  logic              wake_request_out_n;
  logic              wake_request_oe;
  logic [1:0]        power_state_out;
  logic              soft_reset_out;
  logic              irq_out;
  logic [31:0]       rdata;
  logic              err;
  int                failures;
  int                n_compared;
  int                k;

  bridge_power_mgmt_csr #(.SRST_CYCLES(SRST_T)) bridge_power_mgmt_csr_i (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .pm_event_in        (pm_event_in),
    .wake_request_out_n (wake_request_out_n),
    .wake_request_oe    (wake_request_oe),
    .power_state_out    (power_state_out),
    .soft_reset_out     (soft_reset_out),
    .irq_out            (irq_out)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // The first edge keeps a new setup apart from the last release.
  task automatic xfer(input logic we, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= we;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave's answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
    check(rdata, e);
  endtask : rd_chk

  // Pulses the event pin, then waits a bounded time for the pin level.
  task automatic event_wait(input logic exp);
    int n;
    @(posedge pclk);
    pm_event_in <= 1'b1;
    repeat (3) @(posedge pclk);
    pm_event_in <= 1'b0;
    n = 0;
    while (wake_request_out_n !== exp && n < 10) begin
      @(posedge pclk);
      n++;
    end
    #1;
  endtask : event_wait

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    #20000;
    failures++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    failures = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    pm_event_in = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(32'(wake_request_out_n), 32'h1);
    check(32'(wake_request_oe), 32'h0);
    rd_chk(ADDR_PWR_CSR, 32'h0000_0008);
    wr(ADDR_PWR_CSR, 32'hFFFF_FFFF);
    check(32'(power_state_out), 32'(PS_D3));
    rd_chk(ADDR_PWR_CSR, 32'h0000_010B);
    for (k = 1; k <= 2; k++) begin
      wr(ADDR_PWR_CSR, 32'h0000_0100 | 32'(k));
      rd_chk(ADDR_PWR_CSR, 32'h0000_010B);
    end
    rd_chk(ADDR_IRQ_STAT, 32'h0000_0004);
    wr(ADDR_IRQ_EN, 32'h0000_0007);
    check(32'(irq_out), 32'h1);
    wr(ADDR_IRQ_CLR, 32'h0000_0004);
    check(32'(irq_out), 32'h0);
    // Leaving D3 for D0 must give one internal reset of set length.
    wr(ADDR_PWR_CSR, 32'h0000_0100);
    n = 0;
    repeat (10) begin
      if (soft_reset_out === 1'b1) n++;
      @(posedge pclk);
      #1;
    end
    check(32'(n), 32'(SRST_T));
    check(32'(power_state_out), 32'(PS_D0));
    rd_chk(ADDR_PWR_CSR, 32'h0000_0108);
    rd_chk(ADDR_IRQ_STAT, 32'h0000_0002);
    wr(ADDR_IRQ_CLR, 32'h0000_0002);
    event_wait(1'b0);
    check(32'(wake_request_out_n), 32'h0);
    check(32'(wake_request_oe), 32'h1);
    rd_chk(ADDR_PWR_CSR, 32'h0000_8108);
    check(32'(irq_out), 32'h1);
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    check(32'(irq_out), 32'h0);
    wr(ADDR_PWR_CSR, 32'h0000_8100);
    repeat (3) @(posedge pclk);
    #1;
    check(32'(wake_request_out_n), 32'h1);
    rd_chk(ADDR_PWR_CSR, 32'h0000_0108);
    // With the enable off, a wake event is recorded but not driven.
    wr(ADDR_PWR_CSR, 32'h0000_0003);
    event_wait(1'b0);
    check(32'(wake_request_out_n), 32'h1);
    rd_chk(ADDR_PWR_CSR, 32'h0000_800B);
    xfer(1'b1, ADDR_PWR_CSR, 32'h0000_0103, 4'h1);
    rd_chk(ADDR_PWR_CSR, 32'h0000_800B);
    wr(ADDR_PWR_CSR, 32'h0000_0103);
    repeat (3) @(posedge pclk);
    #1;
    check(32'(wake_request_out_n), 32'h0);
    xfer(1'b0, 12'h0F0, 32'h0000_0000, 4'hF);
    check(32'(err), 32'h1);
    check(rdata, 32'h0000_0000);
    wr(ADDR_IRQ_STAT, 32'h0000_0000);
    rd_chk(ADDR_IRQ_STAT, 32'h0000_0001);
    rd_chk(ADDR_IRQ_CLR, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(32'(wake_request_out_n), 32'h1);
    check(32'(wake_request_oe), 32'h0);
    check(32'(power_state_out), 32'(PS_D0));
    rd_chk(ADDR_PWR_CSR, 32'h0000_0008);
    stop_test();
  end

endmodule : bridge_power_mgmt_csr_tb
`default_nettype wire
